// ===== logic/beam_teach_sequencer.sv
// Teach sequencer of a light curtain receiver with APB registers.
// Assumes beam, level and regulation signals come from logic on pclk;
// only the teach line arrives from a pin.
// How it works
// - A teach regulates all unsuppressed beams to the selected reserve.
// - Reserve has exactly three levels: high, medium, low.
// - Reserve resets to high.
// - Option chooses non-volatile or powered-only retention; default non-volatile.
// - Requests come from panel, teach line, fieldbus and configuration bus.
// - A teach runs in measurement and in alignment operation.
// - Configured blanking areas exclude suppressed beams from regulation.
// - Without blanking areas, any interrupted beam ends teach with error.
// - Auto blanking widens interrupted regions by a margin of beams.
// - At most four blanking areas, each a contiguous run.
// - At most half the beams may be suppressed.
// - Waiting shown during teach; measurement display returns afterwards.
// - Alignment display returns afterwards; success shows both bars full.
// - A failed teach shows no bars for first and last beam.
// - Line pulse longer than 20 ms, shorter than 80 ms starts teach.
// - Line active level follows configured sourcing or sinking polarity.
module beam_teach_sequencer
    import teach_pkg::*;
#(
    parameter int NUM_BEAMS = 32,
    parameter int MARGIN_MAX = 3,
    parameter int unsigned LINE_MIN = LINE_MIN_CYCLES,
    parameter int unsigned LINE_MAX = LINE_MAX_CYCLES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Teach requests
    input wire logic panel_teach_req,
    input wire logic fieldbus_teach_req,
    input wire logic configurable_line_one,
    // Receiver front end
    input wire logic [NUM_BEAMS-1:0] beam_interrupted,
    input wire logic [3:0] first_beam_level,
    input wire logic [3:0] last_beam_level,
    // Regulation engine
    output logic regulate_start,
    output logic [1:0] regulate_reserve,
    output logic [NUM_BEAMS-1:0] regulate_mask,
    input wire logic regulate_done,
    input wire logic regulate_fail,
    output logic nonvolatile_store,
    // Display
    output logic display_waiting,
    output logic display_alignment,
    output logic [3:0] first_beam_bar,
    output logic [3:0] last_beam_bar
);
    localparam int CW = $clog2(NUM_BEAMS + 1);
    localparam int LW = $clog2(LINE_MAX + 1);

    initial begin
        if (NUM_BEAMS < 2 || NUM_BEAMS > 32 || MARGIN_MAX < 0 || MARGIN_MAX > 3)
            $error("beam_teach_sequencer: unsupported beam count or margin");
        if (LINE_MIN == 0 || LINE_MIN >= LINE_MAX)
            $error("beam_teach_sequencer: bad line pulse limits");
    end

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic [31:0] ctrl;
    logic [31:0] next_ctrl;
    logic busy, success, failed;
    logic [1:0] source;
    logic [NUM_BEAMS-1:0] suppressed;
    logic [CW-1:0] suppressed_count;
    teach_state_type state;

    // Decode, zero wait state, error on unmapped offsets
    wire access = psel && penable;
    wire hit_ctrl = paddr == CTRL_OFFSET;
    wire hit_cmd = paddr == CMD_OFFSET;
    wire hit_status = paddr == STATUS_OFFSET;
    wire hit_mask = paddr == MASK_OFFSET;
    wire mapped = hit_ctrl || hit_cmd || hit_status || hit_mask;
    wire ctrl_write = access && pwrite && hit_ctrl;
    wire config_teach_req = access && pwrite && hit_cmd && pwdata[CMD_TEACH_POS];
    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    // Field views of the control register
    wire [1:0] reserve = ctrl[CTRL_RESERVE_POS +: 2];
    wire keep_volatile = ctrl[CTRL_VOLATILE_POS];
    wire [2:0] areas = ctrl[CTRL_AREAS_POS +: 3];
    wire [1:0] margin = ctrl[CTRL_MARGIN_POS +: 2];
    wire line_en = ctrl[CTRL_LINE_EN_POS];
    wire line_high = ctrl[CTRL_LINE_HIGH_POS];
    wire [1:0] wr_reserve = pwdata[CTRL_RESERVE_POS +: 2];
    wire [2:0] wr_areas = pwdata[CTRL_AREAS_POS +: 3];

    // Control write: illegal reserve code keeps old level, areas clamp
    always_comb begin
        next_ctrl = 32'h0000_0000;
        next_ctrl[CTRL_RESERVE_POS +: 2] = (wr_reserve == RESERVE_BAD) ? reserve : wr_reserve;
        next_ctrl[CTRL_VOLATILE_POS] = pwdata[CTRL_VOLATILE_POS];
        next_ctrl[CTRL_ALIGN_POS] = pwdata[CTRL_ALIGN_POS];
        next_ctrl[CTRL_AREAS_POS +: 3] = (wr_areas > MAX_AREAS) ? MAX_AREAS : wr_areas;
        next_ctrl[CTRL_MARGIN_POS +: 2] = pwdata[CTRL_MARGIN_POS +: 2];
        next_ctrl[CTRL_LINE_EN_POS] = pwdata[CTRL_LINE_EN_POS];
        next_ctrl[CTRL_LINE_HIGH_POS] = pwdata[CTRL_LINE_HIGH_POS];
    end

    // Control register; reset gives high reserve and permanent storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RESET;
        end else if (ctrl_write) begin
            ctrl <= next_ctrl;
        end
    end

    // Read data mux
    wire [31:0] status_word = {16'h0000, 8'(suppressed_count), 3'h0, source, failed,
                               success, busy};
    wire [31:0] rd_mux = hit_ctrl ? ctrl :
                         hit_status ? status_word :
                         hit_mask ? 32'(suppressed) : 32'h0000_0000;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    // ------------------------------------------------------------
    // Teach line input
    // ------------------------------------------------------------
    logic line_meta, line_sync, line_prev;
    logic [LW-1:0] line_cnt;

    // Two-stage synchroniser, then active level per polarity
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_meta <= 1'b0;
            line_sync <= 1'b0;
        end else begin
            line_meta <= configurable_line_one;
            line_sync <= line_meta;
        end
    end
    wire line_active = line_en && (line_high ? line_sync : !line_sync);
    wire line_fell = line_prev && !line_active;
    wire line_req = line_fell && line_cnt > LW'(LINE_MIN) && line_cnt < LW'(LINE_MAX);

    // Pulse length counter, saturating at the upper limit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_prev <= 1'b0;
            line_cnt <= '0;
        end else begin
            line_prev <= line_active;
            if (!line_active)
                line_cnt <= '0;
            else if (line_cnt != LW'(LINE_MAX))
                line_cnt <= line_cnt + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Request arbitration
    // ------------------------------------------------------------
    wire any_req = panel_teach_req || line_req || fieldbus_teach_req || config_teach_req;
    wire [1:0] req_src = panel_teach_req ? SRC_PANEL :
                         line_req ? SRC_LINE :
                         fieldbus_teach_req ? SRC_FIELDBUS : SRC_CONFIG;
    // Accepted in either operating mode, only when idle
    wire start = any_req && state == IDLE_ST;

    // ------------------------------------------------------------
    // Blanking evaluation on the captured beam picture
    // ------------------------------------------------------------
    logic [NUM_BEAMS-1:0] captured, widened;
    logic [CW-1:0] runs, wide_count;
    always_comb begin
        widened = '0;
        runs = '0;
        wide_count = '0;
        // Shifts keep every index in range at the curtain ends
        for (int k = 0; k <= MARGIN_MAX; k++) begin
            if (k <= int'(margin))
                widened = widened | (captured << k) | (captured >> k);
        end
        for (int i = 0; i < NUM_BEAMS; i++) begin
            if (widened[i]) wide_count = wide_count + 1'b1;
            if (widened[i] && (i == 0 || !widened[i == 0 ? 0 : i - 1]))
                runs = runs + 1'b1;
        end
    end
    wire no_blank_fail = areas == 3'h0 && |captured;
    wire area_fail = areas != 3'h0 && runs > CW'(areas);
    wire half_fail = areas != 3'h0 && wide_count > CW'(NUM_BEAMS / 2);
    wire check_fail = no_blank_fail || area_fail || half_fail;

    // ------------------------------------------------------------
    // Teach sequence
    // ------------------------------------------------------------
    teach_state_type next_state;
    always_comb begin
        case (state)
            IDLE_ST: next_state = start ? CAPTURE_ST : IDLE_ST;
            CAPTURE_ST: next_state = CHECK_ST;
            CHECK_ST: next_state = check_fail ? IDLE_ST : REGULATE_ST;
            REGULATE_ST: next_state = WAIT_ST;
            WAIT_ST: next_state = regulate_done ? IDLE_ST : WAIT_ST;
            default: next_state = IDLE_ST;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= IDLE_ST;
            source <= SRC_PANEL;
            captured <= '0;
        end else begin
            state <= next_state;
            if (start) source <= req_src;
            if (state == CAPTURE_ST) captured <= beam_interrupted;
        end
    end

    // Outcome flags and blanking result; an outcome beats a clearing write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            success <= 1'b0;
            failed <= 1'b0;
            suppressed <= '0;
            suppressed_count <= '0;
        end else if (state == CHECK_ST) begin
            failed <= check_fail;
            suppressed <= (areas == 3'h0) ? '0 : widened;
            suppressed_count <= (areas == 3'h0) ? '0 : wide_count;
        end else if (state == WAIT_ST && regulate_done) begin
            success <= !regulate_fail;
            failed <= regulate_fail;
        end else if (start || ctrl_write) begin
            success <= 1'b0;
            failed <= 1'b0;
        end
    end

    // Regulation handshake and storage
    assign regulate_start = state == REGULATE_ST;
    assign regulate_reserve = reserve;
    assign regulate_mask = ~suppressed;
    assign nonvolatile_store = state == WAIT_ST && regulate_done && !regulate_fail &&
                               !keep_volatile;

    // ------------------------------------------------------------
    // Display
    // ------------------------------------------------------------
    assign busy = state != IDLE_ST;
    assign display_waiting = busy;
    assign display_alignment = ctrl[CTRL_ALIGN_POS];
    assign first_beam_bar = failed ? 4'h0 : success ? BAR_MAX : first_beam_level;
    assign last_beam_bar = failed ? 4'h0 : success ? BAR_MAX : last_beam_level;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence check_passes;
        state == CHECK_ST && !check_fail;
    endsequence
    sequence regulation_runs;
        regulate_start ##1 state == WAIT_ST;
    endsequence

    AST_REGULATE: assert property (check_passes |=> regulation_runs)
        else $error("Regulation not started after passing check");
    AST_RESERVE: assert property (reserve != RESERVE_BAD)
        else $error("Illegal reserve level held");
    AST_STORE: assert property (state == WAIT_ST && regulate_done && !regulate_fail
        && !keep_volatile |-> nonvolatile_store ##1 success)
        else $error("Permanent store missing on success");
    AST_NO_BLANK: assert property (state == CHECK_ST && areas == 3'h0 && |captured
        |=> failed && state == IDLE_ST)
        else $error("Interrupted beam without blanking did not fail");
    AST_AREAS: assert property (areas <= MAX_AREAS)
        else $error("Too many blanking areas");
    AST_HALF: assert property (success |-> suppressed_count <= CW'(NUM_BEAMS / 2))
        else $error("More than half the beams suppressed");
    AST_WAITING: assert property ($rose(busy) |-> display_waiting [*2])
        else $error("Waiting not shown during teach");
    AST_FULL_BARS: assert property (success |-> first_beam_bar == BAR_MAX
        && last_beam_bar == BAR_MAX)
        else $error("Bars not full after success");
    AST_NO_BARS: assert property (failed |-> first_beam_bar == 4'h0 && last_beam_bar == 4'h0)
        else $error("Bars shown after failed teach");
    AST_SHORT_LINE: assert property (state == IDLE_ST && line_fell
        && line_cnt <= LW'(LINE_MIN) && !panel_teach_req && !fieldbus_teach_req
        && !config_teach_req |=> state == IDLE_ST)
        else $error("Short line pulse started a teach");
    AST_BUSY_IGNORE: assert property (busy && any_req |=> $stable(source))
        else $error("Request taken during running teach");
endmodule

// ===== logic/teach_pkg.sv
// Constants for the beam teach sequencer: register map, field layout,
// reset values and line pulse timing.
// Assumes a 200 MHz APB clock.
package teach_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] CMD_OFFSET = 8'h04;
    localparam logic [7:0] STATUS_OFFSET = 8'h08;
    localparam logic [7:0] MASK_OFFSET = 8'h0C;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int CTRL_RESERVE_POS = 0;
    localparam int CTRL_VOLATILE_POS = 2;
    localparam int CTRL_ALIGN_POS = 3;
    localparam int CTRL_AREAS_POS = 4;
    localparam int CTRL_MARGIN_POS = 8;
    localparam int CTRL_LINE_EN_POS = 12;
    localparam int CTRL_LINE_HIGH_POS = 13;
    localparam logic [31:0] CTRL_RESET = 32'h0000_3108;
    localparam int CMD_TEACH_POS = 0;

    // Performance reserve levels and blanking area limit
    localparam logic [1:0] RESERVE_HIGH = 2'h0;
    localparam logic [1:0] RESERVE_MEDIUM = 2'h1;
    localparam logic [1:0] RESERVE_LOW = 2'h2;
    localparam logic [1:0] RESERVE_BAD = 2'h3;
    localparam logic [2:0] MAX_AREAS = 3'h4;

    // Teach request sources
    localparam logic [1:0] SRC_PANEL = 2'h0;
    localparam logic [1:0] SRC_LINE = 2'h1;
    localparam logic [1:0] SRC_FIELDBUS = 2'h2;
    localparam logic [1:0] SRC_CONFIG = 2'h3;

    // Bar graph full scale
    localparam logic [3:0] BAR_MAX = 4'hF;

    // ------------------------------------------------------------
    // Line pulse timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_KHZ = 200000;
    localparam int unsigned LINE_MIN_MS = 20;
    localparam int unsigned LINE_MAX_MS = 80;
    localparam int unsigned LINE_MIN_CYCLES = LINE_MIN_MS * CLK_KHZ;
    localparam int unsigned LINE_MAX_CYCLES = LINE_MAX_MS * CLK_KHZ;

    typedef enum logic [2:0] {
        IDLE_ST, CAPTURE_ST, CHECK_ST, REGULATE_ST, WAIT_ST
    } teach_state_type;

endpackage

// ===== sim/teach_line_plc.sv
// Model of the controller that drives the teach line with timed pulses.
// Assumes the bench gives it the clock and the configured polarity.
module teach_line_plc (
    // Clock
    input wire logic pclk,
    // Polarity, 1 when the line is sourcing
    input wire logic active_high,
    // Teach line
    output logic line
);
    timeunit 1ns;
    timeprecision 100ps;

    logic active = 1'b0;

    // Line rests inactive and shows the configured active level in a pulse
    assign line = active ? active_high : ~active_high;

    // Drives the teach line to its active level for len clock cycles
    task automatic pulse(input int len);
        @(posedge pclk);
        active <= 1'b1;
        repeat (len) @(posedge pclk);
        active <= 1'b0;
    endtask
endmodule

// ===== sim/beam_teach_sequencer_bench.sv
// Self-checking bench for the beam teach sequencer.
// Assumes shortened line limits of 20 and 80 cycles and the line model.
module beam_teach_sequencer_bench
    import teach_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, line_pin, line_high;
    logic panel_teach_req, fieldbus_teach_req, regulate_done, regulate_fail;
    logic regulate_start, nonvolatile_store, display_waiting, display_alignment;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, beam_interrupted, regulate_mask;
    logic [3:0] first_beam_level, last_beam_level, first_beam_bar, last_beam_bar;
    logic [1:0] regulate_reserve, exp_res;
    int error_cnt, comparisons;

    beam_teach_sequencer #(.NUM_BEAMS(32), .LINE_MIN(20), .LINE_MAX(80)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .panel_teach_req(panel_teach_req), .fieldbus_teach_req(fieldbus_teach_req),
        .configurable_line_one(line_pin), .beam_interrupted(beam_interrupted),
        .first_beam_level(first_beam_level), .last_beam_level(last_beam_level),
        .regulate_start(regulate_start), .regulate_reserve(regulate_reserve),
        .regulate_mask(regulate_mask), .regulate_done(regulate_done),
        .regulate_fail(regulate_fail), .nonvolatile_store(nonvolatile_store),
        .display_waiting(display_waiting), .display_alignment(display_alignment),
        .first_beam_bar(first_beam_bar), .last_beam_bar(last_beam_bar));

    teach_line_plc u_plc (.pclk(pclk), .active_high(line_high), .line(line_pin));

    // Clock of 5 ns period
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Setup cycle, then access until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic ctrl(input logic [31:0] v);
        apb(1'b1, CTRL_OFFSET, v);
        if (v[1:0] != 2'h3) exp_res = v[1:0];
    endtask

    task automatic req(input logic fb);
        @(posedge pclk);
        panel_teach_req <= ~fb;
        fieldbus_teach_req <= fb;
        @(posedge pclk);
        panel_teach_req <= 1'b0;
        fieldbus_teach_req <= 1'b0;
    endtask

    // One teach from a source; outcome 0 ignored, 1 refused at check, 2 regulated
    task automatic teach(input int src, input int len, input logic [31:0] beams,
            input logic rfail, input int exp_r, input logic exp_store);
        int r;
        logic seen;
        logic ok;
        r = 0;
        seen = 1'b0;
        beam_interrupted <= beams;
        case (src)
            0: req(1'b0);
            1: u_plc.pulse(len);
            2: req(1'b1);
            default: apb(1'b1, CMD_OFFSET, 32'h0000_0001);
        endcase
        for (int i = 0; i < 16 && r == 0; i++) begin
            @(posedge pclk);
            #1;
            if (regulate_start === 1'b1) r = 2;
            else if (display_waiting === 1'b1) seen = 1'b1;
            else if (seen) r = 1;
        end
        chk("outcome", r, exp_r);
        if (r == 2) begin
            chk("reserve", regulate_reserve, exp_res);
            @(posedge pclk);
            fieldbus_teach_req <= 1'b1;
            @(posedge pclk);
            fieldbus_teach_req <= 1'b0;
            regulate_done <= 1'b1;
            regulate_fail <= rfail;
            #1;
            chk("store", nonvolatile_store, exp_store & ~rfail);
            chk("busy", display_waiting, 1'b1);
            @(posedge pclk);
            regulate_done <= 1'b0;
            #1;
        end
        chk("waiting", display_waiting, 1'b0);
        if (r != 0) begin
            ok = (r == 2) && !rfail;
            chk("bars", {first_beam_bar, last_beam_bar}, ok ? 8'hFF : 8'h00);
            apb(1'b0, STATUS_OFFSET, 32'h0000_0000);
            chk("status", rd[4:1], {src[1:0], ~ok, ok});
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic check_reset();
        apb(1'b0, CTRL_OFFSET, 32'h0000_0000);
        chk("ctrl", rd, 32'h0000_3108);
        chk("mask", regulate_mask, 32'hFFFF_FFFF);
        chk("mode", display_alignment, 1'b1);
        apb(1'b0, 8'h10, 32'h0000_0000);
        chk("unmapped", err, 1'b1);
    endtask

    task automatic check_reserve();
        for (int i = 0; i < 4; i++) begin
            ctrl(32'h0000_3108 | i);
            #1;
            chk("level", regulate_reserve, exp_res);
        end
        teach(0, 0, 32'h0000_0000, 1'b0, 2, 1'b1);
    endtask

    task automatic check_errors();
        teach(0, 0, 32'h0000_0100, 1'b0, 1, 1'b1);
        teach(2, 0, 32'h0000_0000, 1'b1, 2, 1'b1);
    endtask

    task automatic check_blanking();
        ctrl(32'h0000_3119);
        teach(0, 0, 32'h0000_7FFE, 1'b0, 2, 1'b1);
        chk("suppressed", regulate_mask, 32'hFFFF_0000);
        apb(1'b0, STATUS_OFFSET, 32'h0000_0000);
        chk("count", rd[15:8], 8'h10);
        teach(0, 0, 32'h0000_FFFE, 1'b0, 1, 1'b1);
        teach(0, 0, 32'h0010_0004, 1'b0, 1, 1'b1);
    endtask

    task automatic check_line();
        int lens[4] = '{20, 21, 79, 80};
        int outs[4] = '{0, 2, 2, 0};
        ctrl(32'h0000_3108);
        for (int i = 0; i < 4; i++) teach(1, lens[i], 32'h0000_0000, 1'b0, outs[i], 1'b1);
        line_high <= 1'b0;
        ctrl(32'h0000_1108);
        repeat (30) @(posedge pclk);
        teach(1, 40, 32'h0000_0000, 1'b0, 2, 1'b1);
        ctrl(32'h0000_0108);
        teach(1, 40, 32'h0000_0000, 1'b0, 0, 1'b1);
    endtask

    task automatic check_sources();
        line_high <= 1'b1;
        ctrl(32'h0000_3104);
        #1;
        chk("live", {first_beam_bar, last_beam_bar}, 8'h75);
        teach(3, 0, 32'h0000_0000, 1'b0, 2, 1'b0);
        chk("mode", display_alignment, 1'b0);
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, panel_teach_req, fieldbus_teach_req} = 5'h00;
        {regulate_done, regulate_fail} = 2'h0;
        line_high = 1'b1;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        beam_interrupted = 32'h0000_0000;
        first_beam_level = 4'h7;
        last_beam_level = 4'h5;
        exp_res = 2'h0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        check_reset();
        check_reserve();
        check_errors();
        check_blanking();
        check_line();
        check_sources();
        finish_test();
    end

    // Cuts a hang short well after the expected run length
    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        finish_test();
    end
endmodule
